// >>> shared/seen_pkg.sv
// package: command codes, set indices, widths and reset values for the enable bank
`default_nettype none
package seen_pkg;
    localparam int unsigned SEEN_WIDTH   = 16;
    localparam int unsigned SEEN_SETS    = 4;
    // set indices, also the summary bit order
    localparam logic [1:0]  SEEN_SET_STD  = 2'h0;
    localparam logic [1:0]  SEEN_SET_OPER = 2'h1;
    localparam logic [1:0]  SEEN_SET_MEAS = 2'h2;
    localparam logic [1:0]  SEEN_SET_QUES = 2'h3;
    // command codes decoded from the bus parser
    localparam logic [2:0]  SEEN_CMD_NONE   = 3'h0;
    localparam logic [2:0]  SEEN_CMD_WRITE  = 3'h1;
    localparam logic [2:0]  SEEN_CMD_QUERY  = 3'h2;
    localparam logic [2:0]  SEEN_CMD_PRESET = 3'h3;
    localparam logic [2:0]  SEEN_CMD_CLS    = 3'h4;
    localparam logic [15:0] SEEN_MASK_RST   = 16'h0000;
    // status byte bit positions of the error and master summaries
    localparam int unsigned SEEN_SB_EAV_BIT = 2;
    localparam int unsigned SEEN_SB_MSS_BIT = 6;
    typedef logic [SEEN_WIDTH-1:0] seen_word_t;
endpackage : seen_pkg
`default_nettype wire

// >>> shared/seen_set_if.sv
// interface: one status set's event word, mask and summary
`default_nettype none
interface seen_set_if;
    import seen_pkg::*;
    seen_word_t event_bits;
    seen_word_t mask;
    logic       summary;
    modport bank (output mask, output event_bits, input summary);
    modport gate (input mask, input event_bits, output summary);
endinterface : seen_set_if
`default_nettype wire

// >>> design/seen_gate.sv
// one set's and-or gating from events and enable to summary
`default_nettype none
module seen_gate
    import seen_pkg::*;
(
    seen_set_if.gate s
);
    // combinational so the summary follows events and mask in the same cycle
    assign s.summary = |(s.event_bits & s.mask); // R2 R3 R11
endmodule : seen_gate
`default_nettype wire

// >>> design/seen_top.sv
// top: four event enable masks with command port and summary outputs
//
// Contract
// R1: separate enable mask for each of four sets
// R2: event bit ANDed with matching enable bit
// R3: any gated bit drives set summary high
// R4: writing zero clears the whole mask
// R5: clear-status leaves all masks unchanged
// R6: power-up and preset clear all masks
// R7: masks are 16 bits, values 0 to 65535
// R8: query returns mask without changing it
// R9: event bits stay latched until read or cleared
// R10: status byte error summary B2, master B6
// R11: summary is OR of gated bits, same cycle
`default_nettype none
module seen_top
    import seen_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire logic [2:0]           cmd_i,
    input  wire logic [1:0]           cmd_set_i,
    input  wire logic [15:0]          cmd_data_i,
    input  wire logic [SEEN_SETS-1:0] event_read_i,
    input  wire logic [15:0]          std_event_i,
    input  wire logic [15:0]          oper_event_i,
    input  wire logic [15:0]          meas_event_i,
    input  wire logic [15:0]          ques_event_i,
    input  wire logic                 error_available_summary_i,
    input  wire logic                 error_enable_i,
    output logic [15:0]               query_data_o,
    output logic                      query_valid_o,
    output logic [SEEN_SETS-1:0]      summary_o,
    output logic [7:0]                status_byte_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        seen_word_t [SEEN_SETS-1:0] mask;
        seen_word_t [SEEN_SETS-1:0] latched;
        seen_word_t                 qdata;
        logic                       qvalid;
    } seen_state_t;

    seen_state_t cur;
    seen_state_t next_cur;
    seen_word_t  raw_ev [SEEN_SETS];

    assign raw_ev[SEEN_SET_STD]  = std_event_i;
    assign raw_ev[SEEN_SET_OPER] = oper_event_i;
    assign raw_ev[SEEN_SET_MEAS] = meas_event_i;
    assign raw_ev[SEEN_SET_QUES] = ques_event_i;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // a 16-bit field holds any value 0..65535, whatever radix the parser used
    always_comb
    begin
        next_cur        = cur;
        next_cur.qvalid = 1'b0;
        for (int i = 0; i < SEEN_SETS; i++)
        begin
            // read clears, but a new event in that cycle still lands
            if (event_read_i[i] || cmd_i == SEEN_CMD_CLS)
                next_cur.latched[i] = SEEN_MASK_RST;
            next_cur.latched[i] = next_cur.latched[i] | raw_ev[i]; // R9
        end
        unique case (cmd_i)
            SEEN_CMD_WRITE:
                next_cur.mask[cmd_set_i] = cmd_data_i; // R1 R4 R7
            SEEN_CMD_QUERY:
            begin
                next_cur.qdata  = cur.mask[cmd_set_i]; // R8
                next_cur.qvalid = 1'b1;
            end
            SEEN_CMD_PRESET:
                for (int i = 0; i < SEEN_SETS; i++)
                    next_cur.mask[i] = SEEN_MASK_RST; // R6
            default: ; // clear-status and idle keep masks, R5
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            cur <= '0; // R6
        else
            cur <= next_cur;
    end

    // ------------------------------------------------------------------
    // gating, one instance per set
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < SEEN_SETS; g++)
        begin : g_set
            seen_set_if s ();
            assign s.mask       = cur.mask[g];
            assign s.event_bits = cur.latched[g];
            seen_gate u_gate (.s(s));
            assign summary_o[g] = s.summary; // R3
        end
    endgenerate

    // status byte: error summary and master summary
    always_comb
    begin
        status_byte_o = 8'h00;
        status_byte_o[SEEN_SB_EAV_BIT] = error_available_summary_i; // R10
        status_byte_o[SEEN_SB_MSS_BIT] = error_available_summary_i & error_enable_i; // R10
    end

    assign query_data_o  = cur.qdata;
    assign query_valid_o = cur.qvalid;
endmodule : seen_top
`default_nettype wire

// >>> sim/seen_ctrl.sv
// controller model issuing enable-bank commands
`default_nettype none
module seen_ctrl (input wire logic clk_i, output logic [2:0] cmd_o = '0,
    output logic [1:0] set_o = '0, output logic [15:0] data_o = '0);
    timeunit 1ns; timeprecision 1ps;
    // a command stands until the next call; zero is a legal clearing word
    task automatic send(input logic [2:0] c, logic [1:0] s, logic [15:0] d);
        @(posedge clk_i) {cmd_o, set_o, data_o} <= {c, s, d};
    endtask
    // released data is inverted so a stale word cannot pass as fresh
    task automatic idle();
        @(posedge clk_i) {cmd_o, data_o} <= {3'h0, ~data_o};
    endtask
endmodule // seen_ctrl
`default_nettype wire

// >>> sim/seen_top_asserts.sv
// checker for the enable bank ports
`default_nettype none
module seen_top_asserts (input wire logic clk_sys_i, rstn_i, query_valid_o,
    input wire logic error_available_summary_i, error_enable_i, input wire logic [2:0] cmd_i,
    input wire logic [1:0] cmd_set_i, input wire logic [15:0] cmd_data_i, std_event_i,
    input wire logic [15:0] query_data_o, input wire logic [3:0] summary_o,
    input wire logic [7:0] status_byte_o);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    query_pulse_a: assert property (cmd_i == 3'h2 |=> query_valid_o) else $error("no valid");
    idle_quiet_a: assert property (cmd_i != 3'h2 |=> !query_valid_o) else $error("stray valid");
    write_read_a: assert property (cmd_i == 3'h1 ##1 cmd_i == 3'h2 &&
        cmd_set_i == $past(cmd_set_i)
        |=> query_data_o == $past(cmd_data_i, 2)) else $error("bad readback");
    preset_zero_a: assert property (cmd_i == 3'h3 ##1 cmd_i == 3'h2 |=>
        query_data_o == 16'h0) else $error("preset kept mask");
    zero_write_a: assert property (cmd_i == 3'h1 && cmd_data_i == 16'h0
        |=> !summary_o[$past(cmd_set_i)]) else $error("zero mask summary");
    gate_std_a: assert property (cmd_i == 3'h1 && cmd_set_i == 2'h0 &&
        cmd_data_i == 16'hffff && |std_event_i |=> summary_o[0]) else $error("summary missing");
    eav_bit_a: assert property (status_byte_o[2] == error_available_summary_i)
        else $error("bad bit two");
    mss_bit_a: assert property (
        status_byte_o[6] == (error_available_summary_i && error_enable_i))
        else $error("bad bit six");
    // main scenarios reached
    cover property (query_valid_o);
    cover property (|summary_o);
    cover property (cmd_i == 3'h4);
endmodule // seen_top_asserts
bind seen_top seen_top_asserts u_chk (.*);
`default_nettype wire

// >>> sim/seen_top_test.sv
// self-checking bench for the enable bank
`default_nettype none
module seen_top_test;
    import seen_pkg::*;
    timeunit 1ns; timeprecision 1ps;
    logic clk_sys_i = 0, rstn_i = 0, error_available_summary = 0, een = 0, qv;
    logic [3:0][15:0] ev = '0;
    logic [3:0] rd = '0, sum;
    logic [15:0] qd, cd;
    logic [2:0] cmd;
    logic [1:0] cs;
    logic [7:0] sb;
    int error_cnt = 0, total_checks = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    seen_ctrl u_ctrl (.clk_i(clk_sys_i), .cmd_o(cmd), .set_o(cs), .data_o(cd));
    seen_top u_dut (.clk_sys_i, .rstn_i, .cmd_i(cmd), .cmd_set_i(cs), .cmd_data_i(cd),
        .event_read_i(rd), .std_event_i(ev[0]), .oper_event_i(ev[1]), .meas_event_i(ev[2]),
        .ques_event_i(ev[3]), .error_available_summary_i(error_available_summary), .error_enable_i(een),
        .query_data_o(qd), .query_valid_o(qv), .summary_o(sum), .status_byte_o(sb));
    task automatic chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin error_cnt++; $display("unexpected at %0t: mismatch", $time); end
    endtask
    task automatic qry(input logic [1:0] s, input logic [15:0] e);
        u_ctrl.send(3'h2, s, '0);
        u_ctrl.idle();
        #1 chk(qv === 1'b1 && qd === e);
    endtask
    // one-cycle event set and read clear, judged after the latch edge
    task automatic pulse(input int s, input logic [15:0] v, input logic [3:0] r);
        @(posedge clk_sys_i) {ev[s], rd} <= {v, r};
        @(posedge clk_sys_i) {ev[s], rd} <= '0;
        #1;
    endtask
    task automatic t_masks();
        logic [3:0][15:0] w = {16'h8000, 16'h0800, 16'h0001, 16'hffff};
        for (int s = 0; s < 4; s++) qry(2'(s), SEEN_MASK_RST);
        for (int s = 0; s < 4; s++) u_ctrl.send(3'h1, 2'(s), w[s]);
        for (int s = 0; s < 8; s++) qry(2'(s), w[s%4]);
    endtask
    task automatic t_gate();
        pulse(2, 16'h0400, 4'h0); chk(sum[2] === 1'b0);
        pulse(2, 16'h0800, 4'h0); chk(sum[2] === 1'b1);
        pulse(2, 16'h0000, 4'h0); chk(sum[2] === 1'b1);
        pulse(2, 16'h0000, 4'h4); chk(sum[2] === 1'b0);
    endtask
    task automatic t_clear();
        u_ctrl.send(3'h1, 2'h0, 16'hffff);
        ev[0] <= 16'h0001;
        u_ctrl.idle();
        ev[0] <= '0;
        #1 chk(sum[0] === 1'b1);
        u_ctrl.send(3'h1, 2'h0, 16'h0000);
        qry(2'h0, 16'h0000);
        chk(sum[0] === 1'b0);
        u_ctrl.send(3'h4, 2'h0, '0);
        qry(2'h3, 16'h8000);
        u_ctrl.send(3'h3, 2'h0, '0);
        for (int s = 0; s < 4; s++) qry(2'(s), SEEN_MASK_RST);
    endtask
    task automatic t_sb();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i) {error_available_summary, een} <= 2'(i);
            @(posedge clk_sys_i) #1 chk(sb === {1'b0, i == 3, 3'b0, i >= 2, 2'b0});
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_masks(); t_gate(); t_clear(); t_sb();
        conclude();
    end
    // a hang is cut well past the roughly 70 cycles the tests need
    initial begin #20000; error_cnt++; conclude(); end
endmodule // seen_top_test
`default_nettype wire
